// >>> inc/fault_status_pkg.sv
// Constants, field positions and state types for the controller fault status register.
// Assumes one 250 MHz clock and a synchronous active-low reset shared by all users.
// Function
// - Read-only 32-bit register E2h, resets zero
// - Bit 31 is OR of fault flags
// - Bit 29 position detect frequency fault
// - Bit 28 position detect first timing fault
// - Bit 27 position detect second timing fault
// - Bit 26 bus current limit status
// - Bit 25 resistance/inductance measurement error
// - Bit 24 back-EMF constant measurement error
// - Bit 23 abnormal speed motor lock
// - Bit 22 abnormal back-EMF motor lock
package fault_status_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int          ADDR_W                  = 8;
  localparam int          DATA_W                  = 32;
  localparam int          FLAG_N                  = 16;
  localparam logic [7:0]  CONTROLLER_FAULT_FLAGS_ADDR = 8'hE2;
  localparam logic [31:0] CONTROLLER_FAULT_FLAGS_RESET = 32'h00000000;
  localparam logic [31:0] RESERVED_MASK           = 32'h40003FFF;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int SUMMARY_BIT                        = 31;
  localparam int POSITION_DETECT_FREQUENCY_FAULT_BIT = 29;
  localparam int POSITION_DETECT_FIRST_TIMING_BIT   = 28;
  localparam int POSITION_DETECT_SECOND_TIMING_BIT  = 27;
  localparam int BUS_CURRENT_LIMIT_BIT              = 26;
  localparam int PARAM_MEASURE_RL_BIT               = 25;
  localparam int PARAM_MEASURE_BACKEMF_BIT          = 24;
  localparam int ABNORMAL_SPEED_LOCK_BIT            = 23;
  localparam int ABNORMAL_BACKEMF_LOCK_BIT          = 22;
  localparam int MOTOR_ABSENT_LOCK_BIT              = 21;
  localparam int ROTOR_STALL_LOCK_BIT               = 20;
  localparam int LOCK_CURRENT_LIMIT_BIT             = 19;
  localparam int HARDWARE_LOCK_CURRENT_LIMIT_BIT    = 18;
  localparam int SUPPLY_LOW_FAULT_BIT               = 17;
  localparam int SUPPLY_HIGH_FAULT_BIT              = 16;
  localparam int VELOCITY_LOOP_SATURATED_BIT        = 15;
  localparam int TORQUE_LOOP_SATURATED_BIT          = 14;
  localparam int FLAG_LSB                           = 14;
  localparam int FLAG_GAP_BIT                       = 30;

  // ****************************************
  // State types
  // ****************************************
  typedef struct packed {
    logic [FLAG_N-1:0] flags;
  } capture_state_t;

  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic              rvalid;
  } read_state_t;

endpackage

// >>> verilog/fault_flag_capture.sv
// Registers the controller fault flags and forms the summary bit.
// Assumes raw flags come from detection logic on the same clock.
`timescale 1ns/10ps
module fault_flag_capture
  import fault_status_pkg::*;
(
  input  wire logic              CLK,
  input  wire logic              RSTN,
  input  wire logic [FLAG_N-1:0] raw_flags,
  output logic      [FLAG_N-1:0] flags,
  output logic                   summary
);

  capture_state_t state;
  capture_state_t next_state;

  // ****************************************
  // Per-flag capture
  // ****************************************
  always_comb begin
    next_state = state;
    next_state.flags = raw_flags;
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  genvar i;
  generate
    for (i = 0; i < FLAG_N; i++) begin : g_flag
      assign flags[i] = state.flags[i];
    end
  endgenerate

  assign summary = |state.flags;

endmodule

// >>> verilog/controller_fault_status_reg.sv
// Controller fault status register with its register read/write port.
// Assumes fault detectors share CLK; clearing of flags happens in the detectors.
`timescale 1ns/10ps
module controller_fault_status_reg
  import fault_status_pkg::*;
(
  input  wire logic              CLK,
  input  wire logic              RSTN,
  input  wire logic [ADDR_W-1:0] REG_ADDR,
  input  wire logic              REG_RD,
  input  wire logic              REG_WR,
  input  wire logic [DATA_W-1:0] REG_WDATA,
  output logic      [DATA_W-1:0] REG_RDATA,
  output logic                   REG_RVALID,
  input  wire logic              POSITION_DETECT_FREQUENCY_FAULT,
  input  wire logic              POSITION_DETECT_FIRST_TIMING_FAULT,
  input  wire logic              POSITION_DETECT_SECOND_TIMING_FAULT,
  input  wire logic              BUS_CURRENT_LIMIT,
  input  wire logic              PARAM_MEASURE_RL_FAULT,
  input  wire logic              PARAM_MEASURE_BACKEMF_FAULT,
  input  wire logic              ABNORMAL_SPEED_LOCK,
  input  wire logic              ABNORMAL_BACKEMF_LOCK,
  input  wire logic              MOTOR_ABSENT_LOCK,
  input  wire logic              ROTOR_STALL_LOCK,
  input  wire logic              LOCK_CURRENT_LIMIT,
  input  wire logic              HARDWARE_LOCK_CURRENT_LIMIT,
  input  wire logic              SUPPLY_LOW_FAULT,
  input  wire logic              SUPPLY_HIGH_FAULT,
  input  wire logic              VELOCITY_LOOP_SATURATED,
  input  wire logic              TORQUE_LOOP_SATURATED
);

  logic [FLAG_N-1:0] raw_flags;
  logic [FLAG_N-1:0] flags;
  logic              summary;
  logic [DATA_W-1:0] status_word;
  read_state_t       state;
  read_state_t       next_state;
  logic              write_seen;

  // ****************************************
  // Flag gathering
  // ****************************************
  assign raw_flags = {
    POSITION_DETECT_FREQUENCY_FAULT,
    POSITION_DETECT_FIRST_TIMING_FAULT,
    POSITION_DETECT_SECOND_TIMING_FAULT,
    BUS_CURRENT_LIMIT,
    PARAM_MEASURE_RL_FAULT,
    PARAM_MEASURE_BACKEMF_FAULT,
    ABNORMAL_SPEED_LOCK,
    ABNORMAL_BACKEMF_LOCK,
    MOTOR_ABSENT_LOCK,
    ROTOR_STALL_LOCK,
    LOCK_CURRENT_LIMIT,
    HARDWARE_LOCK_CURRENT_LIMIT,
    SUPPLY_LOW_FAULT,
    SUPPLY_HIGH_FAULT,
    VELOCITY_LOOP_SATURATED,
    TORQUE_LOOP_SATURATED
  };

  fault_flag_capture u_capture (
    .CLK       (CLK),
    .RSTN      (RSTN),
    .raw_flags (raw_flags),
    .flags     (flags),
    .summary   (summary)
  );

  // ****************************************
  // Status word assembly
  // ****************************************
  always_comb begin
    status_word = CONTROLLER_FAULT_FLAGS_RESET;
    status_word[SUMMARY_BIT] = summary;
    status_word[POSITION_DETECT_FREQUENCY_FAULT_BIT:FLAG_LSB] = {flags[FLAG_N-1], 1'b0} == 2'h0
      ? {1'b0, flags[FLAG_N-2:0]}
      : {1'b1, flags[FLAG_N-2:0]};
  end

  // ****************************************
  // Register read port
  // ****************************************
  assign write_seen = REG_WR;

  always_comb begin
    next_state = state;
    next_state.rvalid = REG_RD;
    if (REG_RD) begin
      if (REG_ADDR == CONTROLLER_FAULT_FLAGS_ADDR) begin
        next_state.rdata = status_word;
      end else begin
        next_state.rdata = '0;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      state <= '{rdata: CONTROLLER_FAULT_FLAGS_RESET, rvalid: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  assign REG_RDATA  = state.rdata;
  assign REG_RVALID = state.rvalid;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  sequence s_read_own;
    REG_RD && REG_ADDR == CONTROLLER_FAULT_FLAGS_ADDR;
  endsequence

  sequence s_answer;
    REG_RVALID ##0 (REG_RDATA == $past(status_word));
  endsequence

  sequence s_lone_read;
    REG_RD ##1 !REG_RD;
  endsequence

  sequence s_lone_answer;
    REG_RVALID ##1 !REG_RVALID;
  endsequence

  AST_READ_RETURNS_WORD: assert property (s_read_own |=> s_answer)
    else $error("Read of fault register returned wrong word");

  AST_RESET_ZERO: assert property (disable iff (1'b0)
      !RSTN |=> (status_word == '0 && REG_RDATA == '0 && !REG_RVALID))
    else $error("Fault register not zero after reset");

  AST_ANSWER_PULSE: assert property (s_lone_read |-> s_lone_answer)
    else $error("Read answer not a one-cycle pulse");

  AST_UNMAPPED_ZERO: assert property (
      REG_RD && REG_ADDR != CONTROLLER_FAULT_FLAGS_ADDR |=> REG_RVALID && REG_RDATA == '0)
    else $error("Unmapped address returned data");

  AST_IDLE_HOLDS: assert property (!REG_RD |=> !REG_RVALID && $stable(REG_RDATA))
    else $error("Register port changed without a read");

  AST_SUMMARY_OR: assert property ((status_word[SUMMARY_BIT]) == (|status_word[29:14]))
    else $error("Summary bit differs from OR of flags");

  AST_FREQ_FLAG: assert property (
      $past(RSTN) |->
      status_word[POSITION_DETECT_FREQUENCY_FAULT_BIT] == $past(POSITION_DETECT_FREQUENCY_FAULT))
    else $error("Frequency fault bit wrong");

  AST_T1_FLAG: assert property (
      $past(RSTN) |->
      status_word[POSITION_DETECT_FIRST_TIMING_BIT] == $past(POSITION_DETECT_FIRST_TIMING_FAULT))
    else $error("First timing fault bit wrong");

  AST_T2_FLAG: assert property (
      $past(RSTN) |->
      status_word[POSITION_DETECT_SECOND_TIMING_BIT] == $past(POSITION_DETECT_SECOND_TIMING_FAULT))
    else $error("Second timing fault bit wrong");

  AST_BUS_LIMIT_FLAG: assert property (
      $past(RSTN) |-> status_word[BUS_CURRENT_LIMIT_BIT] == $past(BUS_CURRENT_LIMIT))
    else $error("Bus current limit bit wrong");

  AST_RL_FLAG: assert property (
      $past(RSTN) |-> status_word[PARAM_MEASURE_RL_BIT] == $past(PARAM_MEASURE_RL_FAULT))
    else $error("Resistance measurement bit wrong");

  AST_BACKEMF_FLAG: assert property (
      $past(RSTN) |->
      status_word[PARAM_MEASURE_BACKEMF_BIT] == $past(PARAM_MEASURE_BACKEMF_FAULT))
    else $error("Back-EMF measurement bit wrong");

  AST_SPEED_LOCK_FLAG: assert property (
      RSTN && ABNORMAL_SPEED_LOCK |=>
      status_word[ABNORMAL_SPEED_LOCK_BIT] && status_word[SUMMARY_BIT])
    else $error("Abnormal speed lock not reported");

  AST_BACKEMF_LOCK_FLAG: assert property (
      $past(RSTN) |-> status_word[ABNORMAL_BACKEMF_LOCK_BIT] == $past(ABNORMAL_BACKEMF_LOCK))
    else $error("Abnormal back-EMF lock bit wrong");

  AST_LOW_FLAGS: assert property (
      $past(RSTN) |->
      status_word[MOTOR_ABSENT_LOCK_BIT:TORQUE_LOOP_SATURATED_BIT] == $past(raw_flags[7:0]))
    else $error("Lock, supply or loop flag wrong");

  AST_RESERVED_ZERO: assert property (
      REG_RVALID |-> (REG_RDATA & RESERVED_MASK) == '0)
    else $error("Reserved bit read as one");

  AST_WRITE_NO_EFFECT: assert property (
      write_seen && !REG_RD |=> !REG_RVALID && $stable(REG_RDATA))
    else $error("Write disturbed the register");

endmodule

// >>> tb/host_reader.sv
// Host model that reads and writes the fault status register port.
// Assumes the register port takes a one-cycle read or write pulse on CLK.
`timescale 1ns/10ps
module host_reader
  import fault_status_pkg::*;
(
  input  wire logic              CLK,
  output logic      [ADDR_W-1:0] addr,
  output logic                   rd,
  output logic                   wr,
  output logic      [DATA_W-1:0] wdata,
  input  wire logic [DATA_W-1:0] rdata,
  input  wire logic              rvalid
);
  // ****************************************
  // Idle values
  // ****************************************
  initial begin
    addr  = 8'h00;
    rd    = 1'b0;
    wr    = 1'b0;
    wdata = 32'h00000000;
  end

  // ****************************************
  // Access tasks
  // ****************************************
  task automatic do_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    addr <= a;
    rd   <= 1'b1;
    @(posedge CLK);
    rd   <= 1'b0;
    addr <= ~a;
    do begin
      @(negedge CLK);
      n++;
    end while (rvalid !== 1'b1 && n < 4);
    d = (rvalid === 1'b1 && n == 1) ? rdata : 'x;
  endtask

  task automatic do_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge CLK);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge CLK);
    wr    <= 1'b0;
    addr  <= ~a;
    wdata <= ~v;
  endtask
endmodule

// >>> tb/controller_fault_status_reg_test.sv
// Self-checking bench for the controller fault status register.
// Assumes the host model drives the register port and the bench drives the flags.
`timescale 1ns/10ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin errors++; \
  $display("mismatch %0t got %h exp %h", $time, got, exp); end end
module controller_fault_status_reg_test;
  import fault_status_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic              clk    = 1'b0;
  logic              rstn   = 1'b0;
  logic [15:0]       f      = 16'h0000;
  logic [ADDR_W-1:0] addr;
  logic              rd;
  logic              wr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic              rvalid;
  logic [DATA_W-1:0] d;
  int                errors  = 0;
  int                checked = 0;

  always #2 clk = ~clk;

  // ****************************************
  // Instances
  // ****************************************
  host_reader host (.CLK(clk), .addr(addr), .rd(rd), .wr(wr), .wdata(wdata),
    .rdata(rdata), .rvalid(rvalid));

  controller_fault_status_reg dut (.CLK(clk), .RSTN(rstn), .REG_ADDR(addr),
    .REG_RD(rd), .REG_WR(wr), .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid),
    .POSITION_DETECT_FREQUENCY_FAULT(f[15]), .POSITION_DETECT_FIRST_TIMING_FAULT(f[14]),
    .POSITION_DETECT_SECOND_TIMING_FAULT(f[13]), .BUS_CURRENT_LIMIT(f[12]),
    .PARAM_MEASURE_RL_FAULT(f[11]), .PARAM_MEASURE_BACKEMF_FAULT(f[10]),
    .ABNORMAL_SPEED_LOCK(f[9]), .ABNORMAL_BACKEMF_LOCK(f[8]), .MOTOR_ABSENT_LOCK(f[7]),
    .ROTOR_STALL_LOCK(f[6]), .LOCK_CURRENT_LIMIT(f[5]), .HARDWARE_LOCK_CURRENT_LIMIT(f[4]),
    .SUPPLY_LOW_FAULT(f[3]), .SUPPLY_HIGH_FAULT(f[2]), .VELOCITY_LOOP_SATURATED(f[1]),
    .TORQUE_LOOP_SATURATED(f[0]));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic results;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk_flags(input logic [15:0] v);
    logic [DATA_W-1:0] r;
    @(posedge clk);
    f <= v;
    host.do_read(CONTROLLER_FAULT_FLAGS_ADDR, r);
    `CHK(r, {|v, 1'b0, v, 14'h0000})
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    host.do_read(CONTROLLER_FAULT_FLAGS_ADDR, d);
    `CHK(d, CONTROLLER_FAULT_FLAGS_RESET)
    for (int i = 0; i < 16; i++) begin
      chk_flags(16'h0001 << i);
    end
    chk_flags(16'hFFFF);
    chk_flags(16'h0000);
    chk_flags(16'hA5A5);
    host.do_write(CONTROLLER_FAULT_FLAGS_ADDR, 32'hFFFFFFFF);
    host.do_read(CONTROLLER_FAULT_FLAGS_ADDR, d);
    `CHK(d, {1'b1, 1'b0, 16'hA5A5, 14'h0000})
    host.do_read(8'hE0, d);
    `CHK(d, 32'h00000000)
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK(rdata, 32'h00000000)
    @(posedge clk);
    rstn <= 1'b1;
    chk_flags(16'h8001);
    results;
  end

  // ****************************************
  // Watchdog
  // ****************************************
  initial begin
    #20000;
    errors++;
    results;
  end
endmodule
